// ===== nvpe_ctrl.sv
// NVM program/erase sequencer with an Avalon-MM register slave.
// Assumes a storage array that answers reads in the same cycle and
// acknowledges each erase or word write with a one-cycle pulse.
`include "nvpe_map.svh"
`default_nettype none

module nvpe_ctrl
  import nvpe_pkg::*;
#(
  parameter int ROW_WORDS = `NVPE_ROW_WORDS
) (
  // Clock and resets
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        por_n,
  // Avalon-MM slave
  input  wire logic [11:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Storage array
  output logic      [15:0] arr_addr,
  output logic      [13:0] arr_wdata,
  output logic             arr_read,
  output logic             arr_erase,
  output logic             arr_write,
  input  wire logic        arr_ack,
  input  wire logic [13:0] arr_rdata,
  input  wire logic        arr_protected
);

  localparam int IW = $clog2(ROW_WORDS);

  // ****************************************************************
  // Parameter check
  // ****************************************************************
  if (ROW_WORDS != 32) begin : g_bad
    $error("nvpe_ctrl: row length other than 32 words is not supported");
  end

  // ****************************************************************
  // Address window helpers
  // ****************************************************************
  function automatic logic in_win(input logic [15:0] a, input logic [15:0] lo,
                                  input logic [15:0] hi);
    in_win = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic aux_writable(input logic [15:0] a);
    aux_writable = in_win(a, `NVPE_UID_LO, `NVPE_UID_HI) ||
                   in_win(a, `NVPE_CFG_LO, `NVPE_CFG_HI) ||
                   in_win(a, `NVPE_EE_LO, `NVPE_EE_HI);
  endfunction

  function automatic logic aux_readable(input logic [15:0] a);
    aux_readable = aux_writable(a) ||
                   in_win(a, `NVPE_DID_LO, `NVPE_DID_HI) ||
                   in_win(a, `NVPE_DIA_LO, `NVPE_DIA_HI);
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  nvpe_state_type   state;
  nvpe_state_type   next_state;
  logic [14:0]      nvm_word_address;
  logic [13:0]      nvm_word_data;
  logic             region_select;
  logic             latch_only_load;
  logic             erase_select;
  logic             program_enable;
  logic             program_start;
  logic             read_start;
  logic             program_fault_flag;
  logic [1:0]       key_stage;
  logic [IW-1:0]    word_idx;
  logic             op_live;
  logic             rd_phase;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire       wr_ok    = avs_write && avs_byteenable[0];
  wire [7:0] wb       = avs_writedata[7:0];
  wire       wr_adl   = wr_ok && (avs_address == `NVPE_IDX_ADDR_LO);
  wire       wr_adh   = wr_ok && (avs_address == `NVPE_IDX_ADDR_HI);
  wire       wr_dtl   = wr_ok && (avs_address == `NVPE_IDX_DATA_LO);
  wire       wr_dth   = wr_ok && (avs_address == `NVPE_IDX_DATA_HI);
  wire       wr_ctrl  = wr_ok && (avs_address == `NVPE_IDX_CTRL);
  wire       wr_key   = wr_ok && (avs_address == `NVPE_IDX_KEY);
  wire       idle     = (state == NVPE_IDLE);

  // Unlock sequence decode
  wire       key_one  = wr_key && (wb == `NVPE_KEY_FIRST);
  wire       key_two  = wr_key && (wb == `NVPE_KEY_SECOND) && (key_stage == 2'd1);
  wire       armed    = (key_stage == 2'd2);
  wire       wr_set   = wr_ctrl && wb[`NVPE_BIT_WR];
  wire       broken   = (key_stage != 2'd0) && wr_ok && !key_one && !key_two &&
                        !(armed && wr_set);

  // Start classification, from the erase and latch fields written with the start bit and the stored region bit
  wire       go       = wr_set && armed && idle && wb[`NVPE_BIT_EN];
  wire [15:0] eff_addr = {region_select, nvm_word_address};
  wire       tgt_aux  = region_select;
  wire       tgt_latch = !tgt_aux && !wb[`NVPE_BIT_ERASE] && wb[`NVPE_BIT_LATCH];
  wire       tgt_erase = !tgt_aux && wb[`NVPE_BIT_ERASE];
  wire       tgt_prog = !tgt_aux && !wb[`NVPE_BIT_ERASE] && !wb[`NVPE_BIT_LATCH];
  wire       blocked  = tgt_aux ? (!aux_writable(eff_addr) || arr_protected)
                                : (!tgt_latch && arr_protected);
  wire       go_prot  = go && blocked;
  wire       go_latch = go && !blocked && tgt_latch;
  wire       go_long  = go && !blocked && !tgt_latch;
  wire       rd_go    = wr_ctrl && wb[`NVPE_BIT_RD] && idle && !go;

  // Completion of a self-timed operation
  wire       last_word = (word_idx == IW'(ROW_WORDS - 1));
  wire       op_done  = arr_ack && ((state == NVPE_ERASE) || (state == NVPE_AUXW) ||
                                    ((state == NVPE_PROG) && last_word));
  wire       latch_clr = (state == NVPE_PROG) && op_done;

  // Fault flag set and clear terms
  wire       fault_set = go_prot || broken || (wr_ctrl && wb[`NVPE_BIT_FAULT]);
  wire       fault_clr = wr_ctrl && !wb[`NVPE_BIT_FAULT];

  // ****************************************************************
  // Write latches
  // ****************************************************************
  logic [13:0] latch_word;

  nvpe_latch_bank #(
    .WORDS (ROW_WORDS),
    .WIDTH (14),
    .BLANK (`NVPE_LATCH_BLANK)
  ) u_latch (
    .clk     (clk),
    .rst_n   (rst_n),
    .wr_en   (go_latch),
    .wr_idx  (nvm_word_address[IW-1:0]),
    .wr_data (nvm_word_data),
    .clr_all (latch_clr),
    .rd_idx  (word_idx),
    .rd_data (latch_word)
  );

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_comb begin
    next_state = state;
    case (state)
      NVPE_IDLE: begin
        if (go_long && tgt_erase) begin
          next_state = NVPE_ERASE;
        end else if (go_long && tgt_prog) begin
          next_state = NVPE_PROG;
        end else if (go_long) begin
          next_state = NVPE_AUXW;
        end else if (rd_go) begin
          next_state = NVPE_READ;
        end
      end
      NVPE_READ:  next_state = NVPE_IDLE;
      NVPE_ERASE,
      NVPE_AUXW,
      NVPE_PROG: begin
        if (op_done) begin
          next_state = NVPE_IDLE;
        end
      end
      default:    next_state = NVPE_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= NVPE_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Row word walk
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      word_idx <= '0;
    end else if (idle) begin
      word_idx <= '0;
    end else if (state == NVPE_PROG && arr_ack) begin
      word_idx <= word_idx + IW'(1);
    end
  end

  // ****************************************************************
  // Unlock tracking
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      key_stage <= 2'd0;
    end else if (key_one) begin
      key_stage <= 2'd1;
    end else if (key_two) begin
      key_stage <= 2'd2;
    end else if (wr_ok) begin
      key_stage <= 2'd0;
    end
  end

  // ****************************************************************
  // Software registers cleared by the warm reset rst_n only
  // ****************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nvm_word_address <= `NVPE_ADDR_RESET;
      region_select    <= 1'b0;
      latch_only_load  <= 1'b0;
      erase_select     <= 1'b0;
      program_enable   <= 1'b0;
    end else begin
      if (wr_adl) begin
        nvm_word_address[7:0] <= wb;
      end
      if (wr_adh) begin
        nvm_word_address[14:8] <= wb[6:0];
      end
      if (wr_ctrl) begin
        region_select   <= wb[`NVPE_BIT_REGION];
        latch_only_load <= wb[`NVPE_BIT_LATCH];
        erase_select    <= wb[`NVPE_BIT_ERASE];
        program_enable  <= wb[`NVPE_BIT_EN];
      end
    end
  end

  // Start and read-start: set by software, cleared by hardware only
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      program_start <= 1'b0;
      read_start    <= 1'b0;
    end else begin
      if (go_long) begin
        program_start <= 1'b1;
      end else if (op_done) begin
        program_start <= 1'b0;
      end
      read_start <= rd_go;
    end
  end

  // ****************************************************************
  // State on the power-on reset; a warm reset clears only op_live
  // ****************************************************************
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      op_live <= 1'b0;
    end else if (!rst_n || op_done) begin
      op_live <= 1'b0;
    end else if (go_long) begin
      op_live <= 1'b1;
    end
  end

  // Fault flag; a set in the clearing cycle wins
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      program_fault_flag <= 1'b0;
    end else if (!rst_n) begin
      program_fault_flag <= program_fault_flag | op_live;
    end else if (fault_set) begin
      program_fault_flag <= 1'b1;
    end else if (fault_clr) begin
      program_fault_flag <= 1'b0;
    end
  end

  // Data word, untouched by warm resets
  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      nvm_word_data <= 14'h0000;
    end else if (rst_n) begin
      if (state == NVPE_READ) begin
        nvm_word_data <= (region_select && !aux_readable(eff_addr))
                         ? 14'h0000 : arr_rdata;
      end else begin
        if (wr_dtl) begin
          nvm_word_data[7:0] <= wb;
        end
        if (wr_dth) begin
          nvm_word_data[13:8] <= wb[5:0];
        end
      end
    end
  end

  // ****************************************************************
  // Array port
  // ****************************************************************
  assign arr_addr  = (state == NVPE_PROG)
                     ? {1'b0, nvm_word_address[14:IW], word_idx} : eff_addr;
  assign arr_wdata = (state == NVPE_PROG) ? latch_word : nvm_word_data;
  assign arr_read  = (state == NVPE_READ);
  assign arr_erase = (state == NVPE_ERASE);
  assign arr_write = (state == NVPE_PROG) || (state == NVPE_AUXW);

  // ****************************************************************
  // Bus read path: one wait cycle, then data from a flop
  // ****************************************************************
  wire [7:0] ctrl_view = {1'b0, region_select, latch_only_load, erase_select,
                          program_fault_flag, program_enable, program_start, read_start};
  logic [7:0] rd_mux;

  always_comb begin
    case (avs_address)
      `NVPE_IDX_ADDR_LO: rd_mux = nvm_word_address[7:0];
      `NVPE_IDX_ADDR_HI: rd_mux = {1'b0, nvm_word_address[14:8]};
      `NVPE_IDX_DATA_LO: rd_mux = nvm_word_data[7:0];
      `NVPE_IDX_DATA_HI: rd_mux = {2'b00, nvm_word_data[13:8]};
      `NVPE_IDX_CTRL:    rd_mux = ctrl_view;
      default:           rd_mux = 8'h00;
    endcase
  end

  // Read data capture and wait phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_phase     <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      rd_phase <= avs_read && !rd_phase;
      if (avs_read && !rd_phase) begin
        avs_readdata <= {24'h00_0000, rd_mux};
      end
    end
  end

  assign avs_waitrequest = avs_read && !rd_phase;

endmodule

`default_nettype wire

// ===== nvpe_map.svh
// Register indices, field positions and constant values of the NVM
// program/erase sequencer. Definitions only; included by bare name.
`ifndef NVPE_MAP_SVH
`define NVPE_MAP_SVH

// ****************************************************************
// Register indices (word address on the bus = index)
// ****************************************************************
`define NVPE_IDX_ADDR_LO 12'h81a
`define NVPE_IDX_ADDR_HI 12'h81b
`define NVPE_IDX_DATA_LO 12'h81c
`define NVPE_IDX_DATA_HI 12'h81d
`define NVPE_IDX_CTRL    12'h81e
`define NVPE_IDX_KEY     12'h81f

// ****************************************************************
// Control register field positions
// ****************************************************************
`define NVPE_BIT_RD      0
`define NVPE_BIT_WR      1
`define NVPE_BIT_EN      2
`define NVPE_BIT_FAULT   3
`define NVPE_BIT_ERASE   4
`define NVPE_BIT_LATCH   5
`define NVPE_BIT_REGION  6

// ****************************************************************
// Values
// ****************************************************************
`define NVPE_KEY_FIRST   8'h55
`define NVPE_KEY_SECOND  8'haa
`define NVPE_LATCH_BLANK 14'h03ff
`define NVPE_ADDR_RESET  15'h0000
`define NVPE_ROW_WORDS   32

// Auxiliary region windows (full 16-bit address)
`define NVPE_UID_LO      16'h8000
`define NVPE_UID_HI      16'h8003
`define NVPE_DID_LO      16'h8005
`define NVPE_DID_HI      16'h8006
`define NVPE_CFG_LO      16'h8007
`define NVPE_CFG_HI      16'h800b
`define NVPE_DIA_LO      16'h8100
`define NVPE_DIA_HI      16'h82ff
`define NVPE_EE_LO       16'hf000
`define NVPE_EE_HI       16'hf0ff

`endif

// ===== nvpe_pkg.sv
// Types shared by the NVM program/erase sequencer.
// Assumes nothing of its surroundings.
`default_nettype none

package nvpe_pkg;

  // Sequencer states
  typedef enum logic [2:0] {
    NVPE_IDLE,
    NVPE_READ,
    NVPE_ERASE,
    NVPE_PROG,
    NVPE_AUXW
  } nvpe_state_type;

endpackage

`default_nettype wire

// ===== nvpe_latch_bank.sv
// Row write latches: one word per slot, all slots return to blank at once.
// Assumes a single clock and an active-low asynchronous reset.
`default_nettype none

module nvpe_latch_bank #(
  parameter int          WORDS = 32,
  parameter int          WIDTH = 14,
  parameter logic [13:0] BLANK = 14'h03ff
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // Write side
  input  wire logic                     wr_en,
  input  wire logic [$clog2(WORDS)-1:0] wr_idx,
  input  wire logic [WIDTH-1:0]         wr_data,
  input  wire logic                     clr_all,
  // Read side
  input  wire logic [$clog2(WORDS)-1:0] rd_idx,
  output logic      [WIDTH-1:0]         rd_data
);

  // ****************************************************************
  // Parameter check
  // ****************************************************************
  if (WORDS < 2 || (WORDS & (WORDS - 1)) != 0 || WIDTH != 14) begin : g_bad
    $error("nvpe_latch_bank: WORDS must be a power of two, WIDTH 14");
  end

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [WIDTH-1:0] slot [WORDS];

  // Load one slot or blank them all
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < WORDS; i++) begin
        slot[i] <= BLANK;
      end
    end else if (clr_all) begin
      for (int i = 0; i < WORDS; i++) begin
        slot[i] <= BLANK;
      end
    end else if (wr_en) begin
      slot[wr_idx] <= wr_data;
    end
  end

  assign rd_data = slot[rd_idx];

endmodule

`default_nettype wire

// ===== nvpe_arr_model.sv
// Behavioural storage array facing the NVM sequencer.
// Assumes one clock; acknowledges each erase or word write after a short
// or, with slow high, a long wait.
`default_nettype none

module nvpe_arr_model (
  // Clock and pace
  input  wire logic        clk,
  input  wire logic        slow,
  // Array link
  input  wire logic [15:0] arr_addr,
  input  wire logic [13:0] arr_wdata,
  input  wire logic        arr_read,
  input  wire logic        arr_erase,
  input  wire logic        arr_write,
  output logic             arr_ack,
  output logic      [13:0] arr_rdata,
  output logic             arr_protected
);
  logic [13:0] mem [0:65535];
  logic [3:0]  cnt;

  // Array all zeros at start
  initial begin
    arr_ack = 1'b0;
    cnt = 4'h0;
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 14'h0000;
    end
  end

  // Inverted word outside a read pulse, so stale data never looks valid
  assign arr_rdata = arr_read ? mem[arr_addr] : ~mem[arr_addr];
  // Page 0x01 of program flash is write-protected
  assign arr_protected = (arr_addr[15:8] == 8'h01);

  // Self-timed erase and word write, one-cycle acknowledge
  always @(posedge clk) begin
    arr_ack <= 1'b0;
    if ((arr_erase || arr_write) && !arr_ack) begin
      cnt <= cnt + 4'h1;
      if (cnt >= (slow ? 4'hf : 4'h1)) begin
        cnt <= 4'h0;
        arr_ack <= 1'b1;
        if (arr_erase) begin
          for (int i = 0; i < 32; i++) begin
            mem[{arr_addr[15:5], 5'(i)}] <= 14'h3fff;
          end
        end else begin
          mem[arr_addr] <= arr_wdata;
        end
      end
    end
  end
endmodule

`default_nettype wire

// ===== nvpe_ctrl_chk.sv
// Port checker of the NVM program/erase sequencer.
// Assumes it is bound into every nvpe_ctrl instance.
`default_nettype none

module nvpe_ctrl_chk (
  // Clock and resets
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        por_n,
  // Register bus
  input wire logic [11:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // Storage array
  input wire logic [15:0] arr_addr,
  input wire logic [13:0] arr_wdata,
  input wire logic        arr_read,
  input wire logic        arr_erase,
  input wire logic        arr_write,
  input wire logic        arr_ack,
  input wire logic [13:0] arr_rdata,
  input wire logic        arr_protected
);
  logic       all_n;
  logic       ctl_wr;
  logic [5:0] wcnt;

  // Decodes
  assign all_n = rst_n & por_n;
  assign ctl_wr = avs_write && avs_byteenable[0] && (avs_address == 12'h81e);

  // Words acknowledged since the last control write
  always_ff @(posedge clk or negedge all_n) begin
    if (!all_n) wcnt <= 6'h00;
    else if (ctl_wr) wcnt <= 6'h00;
    else if (arr_write && arr_ack) wcnt <= wcnt + 6'h01;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!all_n);

  // ****************
  // Assertions
  // ****************
  chk_write_nowait: assert property (avs_write |-> !avs_waitrequest)
    else $error("write stalled");
  chk_read_wait: assert property ($rose(avs_read)
    |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read answer timing wrong");
  chk_hi_byte: assert property (avs_read && !avs_waitrequest && avs_address == 12'h81b
    |-> avs_readdata[31:7] == 25'h0)
    else $error("address top bit not zero");
  chk_erase_cause: assert property ($rose(arr_erase)
    |-> $past(ctl_wr && avs_writedata[4] && avs_writedata[2]))
    else $error("erase without erase start");
  chk_erase_hold: assert property (arr_erase && !arr_ack
    |=> arr_erase && $stable(arr_addr))
    else $error("erase dropped early");
  chk_erase_end: assert property (arr_erase && arr_ack |=> !arr_erase && !arr_write)
    else $error("erase not ended");
  chk_read_pulse: assert property (arr_read |=> !arr_read)
    else $error("read pulse too long");
  chk_row_index: assert property (arr_write && !arr_addr[15]
    |-> arr_addr[4:0] == wcnt[4:0])
    else $error("row word order wrong");
  chk_no_enable: assert property (ctl_wr && !avs_writedata[2] && !arr_erase
    && !arr_write |=> !arr_erase && !arr_write)
    else $error("operation without enable");
endmodule

bind nvpe_ctrl nvpe_ctrl_chk u_chk (
  .clk(clk), .rst_n(rst_n), .por_n(por_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .arr_addr(arr_addr), .arr_wdata(arr_wdata),
  .arr_read(arr_read), .arr_erase(arr_erase), .arr_write(arr_write),
  .arr_ack(arr_ack), .arr_rdata(arr_rdata), .arr_protected(arr_protected)
);

`default_nettype wire

// ===== testbench.sv
// Self-checking bench of the NVM program/erase sequencer.
// Assumes the array model and the checker are compiled before it.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, rst_n, por_n, slow;
  logic        avs_read, avs_write, avs_waitrequest;
  logic [11:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable;
  logic [15:0] arr_addr;
  logic [13:0] arr_wdata, arr_rdata;
  logic        arr_read, arr_erase, arr_write, arr_ack, arr_protected;
  int          bad_count = 0;
  int          num_checks = 0;

  nvpe_ctrl DUT (
    .clk(clk), .rst_n(rst_n), .por_n(por_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .arr_addr(arr_addr), .arr_wdata(arr_wdata),
    .arr_read(arr_read), .arr_erase(arr_erase), .arr_write(arr_write),
    .arr_ack(arr_ack), .arr_rdata(arr_rdata), .arr_protected(arr_protected)
  );
  nvpe_arr_model u_arr (
    .clk(clk), .slow(slow), .arr_addr(arr_addr), .arr_wdata(arr_wdata),
    .arr_read(arr_read), .arr_erase(arr_erase), .arr_write(arr_write),
    .arr_ack(arr_ack), .arr_rdata(arr_rdata), .arr_protected(arr_protected)
  );

  // ****************
  // Shared tasks
  // ****************
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic r, input logic [11:0] a, input logic [7:0] d,
                     output logic [15:0] q);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    if (r) avs_read <= 1'b1;
    else avs_write <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      bad_count++;
      $display("MISMATCH handshake expected ready seen waiting");
      complete_run();
    end
    q = avs_readdata[15:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [15:0] q;
    bus(1'b0, a, d, q);
  endtask

  task automatic rd(input string what, input logic [11:0] a, input logic [15:0] exp);
    logic [15:0] q;
    bus(1'b1, a, 8'h00, q);
    check(what, exp, q);
  endtask

  // Fault and start bits of the control register
  task automatic ctl_chk(input string what, input logic [1:0] exp);
    logic [15:0] q;
    bus(1'b1, 12'h81e, 8'h00, q);
    check(what, {14'h0, exp}, {14'h0, q[3], q[1]});
  endtask

  task automatic set_addr(input logic [14:0] a);
    wr(12'h81a, a[7:0]);
    wr(12'h81b, {1'b0, a[14:8]});
  endtask

  task automatic set_data(input logic [13:0] d);
    wr(12'h81c, d[7:0]);
    wr(12'h81d, {2'b00, d[13:8]});
  endtask

  task automatic start(input logic [7:0] c);
    wr(12'h81f, 8'h55);
    wr(12'h81f, 8'haa);
    wr(12'h81e, c);
  endtask

  task automatic wait_idle();
    logic [15:0] q;
    int n;
    n = 0;
    do begin
      bus(1'b1, 12'h81e, 8'h00, q);
      n++;
    end while (q[1] !== 1'b0 && n < 200);
    if (n >= 200) begin
      bad_count++;
      $display("MISMATCH start bit expected clear seen set");
      complete_run();
    end
  endtask

  // Read one word through the sequencer; c carries the region bit
  task automatic nvm_rd(input string what, input logic [14:0] a, input logic [7:0] c,
                        input logic [13:0] exp);
    set_addr(a);
    wr(12'h81e, c | 8'h01);
    rd(what, 12'h81c, {8'h00, exp[7:0]});
    rd(what, 12'h81d, {10'h000, exp[13:8]});
  endtask

  // ****************
  // Scenarios
  // ****************
  task automatic t_reset();
    rd("addr low", 12'h81a, 16'h0000);
    rd("addr high", 12'h81b, 16'h0000);
    rd("control", 12'h81e, 16'h0000);
    rd("key reg", 12'h81f, 16'h0000);
    rd("unmapped", 12'h800, 16'h0000);
  endtask

  task automatic t_bytes();
    wr(12'h81b, 8'hff);
    wr(12'h81a, 8'h34);
    rd("addr high", 12'h81b, 16'h007f);
    rd("addr low", 12'h81a, 16'h0034);
    set_data(14'h3fff);
    rd("data high", 12'h81d, 16'h003f);
    avs_byteenable <= 4'h0;
    wr(12'h81a, 8'h00);
    avs_byteenable <= 4'h1;
    rd("masked write", 12'h81a, 16'h0034);
  endtask

  task automatic t_erase();
    set_addr(15'h0040);
    start(8'h16);
    wait_idle();
    nvm_rd("erased first", 15'h0040, 8'h00, 14'h3fff);
    nvm_rd("erased last", 15'h005f, 8'h00, 14'h3fff);
    nvm_rd("next row", 15'h0060, 8'h00, 14'h0000);
  endtask

  task automatic t_row();
    set_addr(15'h0043);
    set_data(14'h1234);
    start(8'h26);
    set_addr(15'h0045);
    set_data(14'h0abc);
    start(8'h26);
    nvm_rd("latch only", 15'h0043, 8'h00, 14'h3fff);
    set_addr(15'h0040);
    set_data(14'h2222);
    start(8'h06);
    wait_idle();
    nvm_rd("latched word", 15'h0043, 8'h00, 14'h1234);
    nvm_rd("latched word", 15'h0045, 8'h00, 14'h0abc);
    nvm_rd("data ignored", 15'h0040, 8'h00, 14'h03ff);
    set_addr(15'h0060);
    start(8'h06);
    wait_idle();
    nvm_rd("latch reset", 15'h0065, 8'h00, 14'h03ff);
  endtask

  task automatic t_protect();
    set_addr(15'h0100);
    start(8'h16);
    ctl_chk("protected start", 2'b10);
    nvm_rd("protected kept", 15'h0100, 8'h00, 14'h0000);
    ctl_chk("fault cleared", 2'b00);
    wr(12'h81e, 8'h08);
    ctl_chk("fault by software", 2'b10);
    wr(12'h81e, 8'h00);
    start(8'h26);
    ctl_chk("latch ignores guard", 2'b00);
  endtask

  task automatic t_unlock();
    set_addr(15'h0043);
    wr(12'h81f, 8'h55);
    wr(12'h81a, 8'h43);
    ctl_chk("broken unlock", 2'b10);
    wr(12'h81f, 8'haa);
    wr(12'h81e, 8'h16);
    ctl_chk("no start", 2'b00);
    nvm_rd("not erased", 15'h0043, 8'h00, 14'h1234);
    start(8'h12);
    ctl_chk("no enable", 2'b00);
    nvm_rd("no erase", 15'h0043, 8'h00, 14'h1234);
  endtask

  task automatic t_aux();
    wr(12'h81e, 8'h40);
    set_addr(15'h7000);
    set_data(14'h0155);
    start(8'h46);
    wait_idle();
    nvm_rd("eeprom word", 15'h7000, 8'h40, 14'h0155);
    nvm_rd("flash word", 15'h7000, 8'h00, 14'h0000);
    nvm_rd("hole read", 15'h0004, 8'h40, 14'h0000);
    set_addr(15'h0005);
    start(8'h46);
    ctl_chk("id write", 2'b10);
  endtask

  task automatic t_warm();
    slow <= 1'b1;
    wr(12'h81e, 8'h00);
    set_addr(15'h0080);
    set_data(14'h0abc);
    start(8'h16);
    wr(12'h81e, 8'h14);
    ctl_chk("start held", 2'b01);
    rd("addr busy", 12'h81a, 16'h0080);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    slow <= 1'b0;
    ctl_chk("reset fault", 2'b10);
    rd("data kept", 12'h81c, 16'h00bc);
    rd("addr cleared", 12'h81a, 16'h0000);
  endtask

  // Clock at 125 MHz
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Main sequence
  initial begin
    rst_n = 1'b0;
    por_n = 1'b0;
    slow = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 12'h000;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h1;
    repeat (10) @(posedge clk);
    u_arr.mem[16'h8004] = 14'h2aaa;
    rst_n <= 1'b1;
    por_n <= 1'b1;
    t_reset();
    t_bytes();
    t_erase();
    t_row();
    t_protect();
    t_unlock();
    t_aux();
    t_warm();
    complete_run();
  end
endmodule

`default_nettype wire
